//--- logic/ifrl_pkg.sv
/*
  shared constants of the field readback loop: register pointers, field layout,
  loop codes, unlock value, host command registers and bit timing.
  assumes a single pclk domain for both ends.
*/
package ifrl_pkg;

  // ---------------------------------------------------------------
  // device register map
  // ---------------------------------------------------------------
  localparam int          FIELD_W       = 12;
  localparam logic [7:0]  REG_CFG       = 8'h27;
  localparam logic [7:0]  REG_HI        = 8'h28;
  localparam logic [7:0]  REG_LO        = 8'h29;
  localparam logic [7:0]  REG_KEY       = 8'h35;
  localparam logic [31:0] KEY_VALUE     = 32'h2c413534;
  localparam int          LOOP_LSB      = 2;
  localparam int          LOOP_MSB      = 3;
  localparam int          SLEEP_BIT     = 0;
  localparam logic [1:0]  LOOP_FAST     = 2'b01;
  localparam logic [1:0]  LOOP_FULL     = 2'b10;
  localparam logic [1:0]  LOOP_RESET    = 2'b00;
  localparam logic        SLEEP_RESET   = 1'b0;
  localparam logic [6:0]  SLAVE_ADDR_DEF = 7'h60;

  // ---------------------------------------------------------------
  // host command registers
  // ---------------------------------------------------------------
  localparam logic [7:0]  APB_CTRL      = 8'h00;
  localparam logic [7:0]  APB_WDATA     = 8'h04;
  localparam logic [7:0]  APB_STATUS    = 8'h08;
  localparam logic [7:0]  APB_RXDATA    = 8'h0c;
  localparam logic [7:0]  APB_JOIN_XY   = 8'h10;
  localparam logic [7:0]  APB_JOIN_ZT   = 8'h14;
  localparam int          CTL_GO        = 0;
  localparam int          CTL_RD        = 1;
  localparam int          CTL_ABORT     = 2;
  localparam int          CTL_REG_LSB   = 8;
  localparam int          CTL_CNT_LSB   = 16;
  localparam int          FIFO_DEPTH    = 16;

  // ---------------------------------------------------------------
  // bit timing
  // ---------------------------------------------------------------
  localparam int          PCLK_PERIOD_NS  = 4;
  localparam int          SCL_QUARTER_NS  = 250;
  localparam int          SCL_QUARTER_CYC =
    (SCL_QUARTER_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;

endpackage : ifrl_pkg

//--- logic/ifrl_if.sv
/*
  two-wire link between host and sensor end.
  assumes both ends run on pclk; sda is resolved here from the two pull-down enables.
*/
`timescale 1ns/10ps
`default_nettype none

interface ifrl_if;
  logic scl;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic sda;

  // ---------------------------------------------------------------
  // open-drain wired and
  // ---------------------------------------------------------------
  assign sda = ~(host_sda_oe | dev_sda_oe);

  modport host (output scl, output host_sda_oe, input sda);
  modport dev  (input scl, input sda, output dev_sda_oe);
endinterface : ifrl_if

`default_nettype wire

//--- logic/ifrl_dev.sv
/*
  sensor end: serial target with loop readback of field and temperature words.
  assumes scl and sda synchronous to pclk, and presetn standing for power-up.
*/
// Overview of operation
// R1 - loop code lives in bits 3:2 of 0x27
// R2 - power-up mode is single register access
// R3 - codes 00 and 11 mean single mode
// R4 - code 01 repeats truncated high parts only
// R5 - code 10 repeats full twelve-bit fields
// R6 - 0x28 holds x, y, z high bytes
// R7 - 0x28 bits 5:0 hold temperature high part
// R8 - 0x29 holds x, y, z low nibbles
// R9 - 0x29 bits 5:0 hold temperature low part
// R10 - host joins high byte and low nibble
// R11 - joined value is twelve-bit two's complement
// R12 - host reads both words in one transfer
// R13 - send msb first, ack continues next address
// R14 - writes ignored until unlock, except sleep
// R15 - nack then stop ends the transmission
// R16 - full loop wraps 0x29 back to 0x28
// R17 - fast loop restarts 0x28 with fresh sample
// R18 - writes to measurement words acked, ignored
`timescale 1ns/10ps
`default_nettype none

module ifrl_dev #(
  parameter logic [6:0] SLAVE_ADDR = ifrl_pkg::SLAVE_ADDR_DEF
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  ifrl_if.dev                               bus,
  input  wire logic [ifrl_pkg::FIELD_W-1:0] x_field,
  input  wire logic [ifrl_pkg::FIELD_W-1:0] y_field,
  input  wire logic [ifrl_pkg::FIELD_W-1:0] z_field,
  input  wire logic [ifrl_pkg::FIELD_W-1:0] temp_field,
  output logic      [1:0]                   loop_mode,
  output logic                              sleep,
  output logic                              unlocked
);
  import ifrl_pkg::*;

  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_PTR, D_WDATA, D_TX} ifrl_dstate_t;

  ifrl_dstate_t state;
  logic         scl_q;
  logic         sda_q;
  logic         sda_oe;
  logic [3:0]   bitcnt;
  logic [7:0]   rxsh;
  logic [7:0]   ptr;
  logic [7:0]   load_ptr;
  logic [1:0]   bsel;
  logic [31:0]  txsh;
  logic [31:0]  wbuf;
  logic [31:0]  live_hi;
  logic [31:0]  live_lo;
  logic [31:0]  snap_lo;
  logic [31:0]  load_word;
  logic         start_c;
  logic         stop_c;
  logic         rise;
  logic         fall;
  logic         addr_hit;
  logic         load_ev;
  logic         commit;

  // ---------------------------------------------------------------
  // pointer step after the last byte of a word
  // ---------------------------------------------------------------
  function automatic logic [7:0] loop_next(input logic [7:0] p, input logic [1:0] m);
    if (m == LOOP_FAST && p == REG_HI) return REG_HI; // R17
    if (m == LOOP_FULL && p == REG_LO) return REG_HI; // R16
    return p + 8'h01; // R3 R13
  endfunction : loop_next

  // ---------------------------------------------------------------
  // line edges and bus conditions
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= bus.scl;
      sda_q <= bus.sda;
    end
  end

  assign start_c  = scl_q & bus.scl & sda_q & ~bus.sda;
  assign stop_c   = scl_q & bus.scl & ~sda_q & bus.sda;
  assign rise     = bus.scl & ~scl_q;
  assign fall     = ~bus.scl & scl_q;
  assign addr_hit = (rxsh[7:1] == SLAVE_ADDR);

  // ---------------------------------------------------------------
  // measurement words
  // ---------------------------------------------------------------
  assign live_hi = {x_field[11:4], y_field[11:4], z_field[11:4], // R6
                    2'b00, temp_field[11:6]}; // R7
  assign live_lo = {12'h000, x_field[3:0], y_field[3:0], z_field[3:0], // R8
                    2'b00, temp_field[5:0]}; // R9

  assign load_ptr = (state == D_TX) ? loop_next(ptr, loop_mode) : ptr;
  assign load_ev  = fall && bitcnt == 4'd9 &&
                    ((state == D_ADDR && rxsh[0]) || (state == D_TX && bsel == 2'd3));
  assign commit   = fall && bitcnt == 4'd9 && state == D_WDATA && bsel == 2'd3;

  always_comb begin
    if (load_ptr == REG_HI) begin
      load_word = live_hi; // R5
    end else if (load_ptr == REG_LO) begin
      load_word = snap_lo;
    end else if (load_ptr == REG_CFG) begin
      load_word = {28'h0000000, loop_mode, 1'b0, sleep};
    end else begin
      load_word = 32'h00000000;
    end
  end

  // ---------------------------------------------------------------
  // low word frozen with each fresh high word
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_lo <= 32'h00000000;
    end else if (load_ev && load_ptr == REG_HI) begin
      snap_lo <= live_lo; // R16
    end
  end

  // ---------------------------------------------------------------
  // byte engine
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state  <= D_IDLE;
      bitcnt <= 4'd0;
      rxsh   <= 8'h00;
      txsh   <= 32'h00000000;
      wbuf   <= 32'h00000000;
      ptr    <= 8'h00;
      bsel   <= 2'd0;
      sda_oe <= 1'b0;
    end else if (start_c) begin
      state  <= D_ADDR;
      bitcnt <= 4'd0;
      bsel   <= 2'd0;
      sda_oe <= 1'b0;
    end else if (stop_c) begin
      state  <= D_IDLE; // R15
      sda_oe <= 1'b0;
    end else if (state != D_IDLE) begin
      if (rise) begin
        if (state == D_TX) begin
          if (bitcnt < 4'd8) begin
            bitcnt <= bitcnt + 4'd1;
          end else if (bitcnt == 4'd8) begin
            if (bus.sda) begin
              state <= D_IDLE; // R15
            end else begin
              bitcnt <= 4'd9; // R13
            end
          end
        end else if (bitcnt < 4'd8) begin
          rxsh   <= {rxsh[6:0], bus.sda};
          bitcnt <= bitcnt + 4'd1;
        end
      end else if (fall) begin
        if (bitcnt == 4'd9) begin
          bitcnt <= 4'd0;
          sda_oe <= 1'b0;
          unique case (state)
            D_ADDR: state <= rxsh[0] ? D_TX : D_PTR;
            D_PTR: begin
              ptr   <= rxsh;
              state <= D_WDATA;
              bsel  <= 2'd0;
            end
            D_WDATA: begin
              bsel <= bsel + 2'd1;
              if (bsel == 2'd3) begin
                ptr <= ptr + 8'h01;
              end
            end
            D_TX: begin
              bsel <= bsel + 2'd1;
              if (bsel == 2'd3) begin
                ptr <= load_ptr; // R4
              end
            end
            default: state <= D_IDLE;
          endcase
          if (load_ev) begin
            txsh   <= load_word;
            sda_oe <= ~load_word[31]; // R13
          end else if (state == D_TX) begin
            txsh   <= txsh << 1;
            sda_oe <= ~txsh[30];
          end
        end else if (bitcnt == 4'd8) begin
          if (state == D_TX) begin
            sda_oe <= 1'b0;
          end else begin
            sda_oe <= (state != D_ADDR) || addr_hit; // R18
            bitcnt <= 4'd9;
            if (state == D_ADDR && !addr_hit) begin
              state <= D_IDLE;
            end
            if (state == D_WDATA) begin
              wbuf <= {wbuf[23:0], rxsh};
            end
          end
        end else if (state == D_TX && bitcnt != 4'd0) begin
          txsh   <= txsh << 1;
          sda_oe <= ~txsh[30]; // R13
        end
      end
    end
  end

  assign bus.dev_sda_oe = sda_oe;

  // ---------------------------------------------------------------
  // configuration and unlock
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_mode <= LOOP_RESET; // R2
      sleep     <= SLEEP_RESET;
      unlocked  <= 1'b0;
    end else if (commit) begin
      if (ptr == REG_KEY && wbuf == KEY_VALUE) begin
        unlocked <= 1'b1; // R14
      end
      if (ptr == REG_CFG) begin
        sleep <= wbuf[SLEEP_BIT]; // R14
        if (unlocked) begin
          loop_mode <= wbuf[LOOP_MSB:LOOP_LSB]; // R1
        end
      end
    end
  end

endmodule : ifrl_dev

`default_nettype wire

//--- logic/ifrl_host.sv
/*
  host end: apb-driven serial controller with receive fifo and field joiner.
  assumes an apb master on pclk and the sensor end on the other side of ifrl_if.
*/
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module ifrl_fifo #(
  parameter int W = 8,
  parameter int D = ifrl_pkg::FIFO_DEPTH
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic      [W-1:0] out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt != (AW+1)'(D));
  assign out_valid = (cnt != '0);
  assign out_data  = mem[rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      wp  <= push ? wp + 1'b1 : wp;
      rp  <= pop ? rp + 1'b1 : rp;
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ifrl_fifo

module ifrl_host #(
  parameter int         QUARTER    = ifrl_pkg::SCL_QUARTER_CYC,
  parameter logic [6:0] SLAVE_ADDR = ifrl_pkg::SLAVE_ADDR_DEF,
  parameter int         DEPTH      = ifrl_pkg::FIFO_DEPTH
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  ifrl_if.host             bus
);
  import ifrl_pkg::*;

  typedef enum logic [3:0] {H_IDLE, H_START, H_SAW, H_REG, H_WDATA,
                            H_RSTART, H_SAR, H_RDATA, H_STOP} ifrl_hstate_t;

  ifrl_hstate_t state;
  logic [15:0]  div;
  logic [1:0]   q;
  logic [3:0]   bitc;
  logic [7:0]   bytec;
  logic [7:0]   rxsh;
  logic [7:0]   txbyte;
  logic [7:0]   cmd_reg;
  logic [7:0]   cmd_cnt;
  logic [31:0]  wdata;
  logic         cmd_rd;
  logic         abort;
  logic         ack_bad;
  logic         nack_err;
  logic         scl_c;
  logic         oe_c;
  logic         scl_r;
  logic         oe_r;
  logic         tick;
  logic         adv;
  logic         is_byte;
  logic         last;
  logic         push;
  logic         go;
  logic         f_ready;
  logic         f_valid;
  logic [7:0]   f_data;
  logic [63:0]  jw;
  logic [55:0]  jbuf;
  logic [2:0]   jidx;
  logic         join_v;
  logic [31:0]  join_xy;
  logic [31:0]  join_zt;

  function automatic logic [15:0] sx(input logic [11:0] v);
    return {{4{v[11]}}, v}; // R11
  endfunction : sx

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = psel & penable & !(paddr inside {APB_CTRL, APB_WDATA, APB_STATUS,
                                                    APB_RXDATA, APB_JOIN_XY, APB_JOIN_ZT});
  assign go      = psel & penable & pwrite & paddr == APB_CTRL & pwdata[CTL_GO] &
                   state == H_IDLE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable) begin
      case (paddr)
        APB_CTRL:    prdata <= {8'h00, cmd_cnt, cmd_reg, 5'h00, abort, cmd_rd, 1'b0};
        APB_WDATA:   prdata <= wdata;
        APB_STATUS:  prdata <= {28'h0000000, join_v, f_valid, nack_err, state != H_IDLE};
        APB_RXDATA:  prdata <= {23'h000000, f_valid, f_data};
        APB_JOIN_XY: prdata <= join_xy;
        APB_JOIN_ZT: prdata <= join_zt;
        default:     prdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_rd  <= 1'b0;
      cmd_reg <= 8'h00;
      cmd_cnt <= 8'h00;
      wdata   <= 32'h00000000;
      abort   <= 1'b0;
    end else begin
      if (go) begin
        cmd_rd  <= pwdata[CTL_RD];
        cmd_reg <= pwdata[CTL_REG_LSB +: 8];
        cmd_cnt <= pwdata[CTL_CNT_LSB +: 8];
      end
      if (psel & penable & pwrite & paddr == APB_WDATA & state == H_IDLE) begin
        wdata <= pwdata;
      end
      if (psel & penable & pwrite & paddr == APB_CTRL & pwdata[CTL_ABORT] &
          state != H_IDLE) begin
        abort <= 1'b1;
      end else if (state == H_IDLE) begin
        abort <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // bit timing and line drive
  // ---------------------------------------------------------------
  assign tick    = (div == 16'(QUARTER - 1));
  assign adv     = tick && !(state == H_RDATA && bitc == 4'd0 && q == 2'd0 && !f_ready);
  assign is_byte = state inside {H_SAW, H_REG, H_WDATA, H_SAR, H_RDATA};
  assign last    = (cmd_cnt != 8'h00) && (bytec == cmd_cnt - 8'h01);
  assign push    = adv && q == 2'd3 && state == H_RDATA && bitc == 4'd8;

  always_comb begin
    unique case (state)
      H_SAW:   txbyte = {SLAVE_ADDR, 1'b0};
      H_SAR:   txbyte = {SLAVE_ADDR, 1'b1};
      H_WDATA: txbyte = wdata[{~bytec[1:0], 3'b111} -: 8];
      default: txbyte = cmd_reg;
    endcase
    scl_c = (q == 2'd1) || (q == 2'd2);
    unique case (state)
      H_IDLE:           begin scl_c = 1'b1; oe_c = 1'b0; end
      H_START:          begin scl_c = (q != 2'd3); oe_c = q[1]; end
      H_RSTART:         oe_c = q[1];
      H_STOP:           begin scl_c = (q != 2'd0); oe_c = !q[1]; end
      H_RDATA:          oe_c = bitc == 4'd8 && !last && !abort; // R12
      default:          oe_c = bitc != 4'd8 && !txbyte[3'(4'd7 - bitc)];
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div   <= 16'h0000;
      scl_r <= 1'b1;
      oe_r  <= 1'b0;
    end else begin
      div   <= (tick || state == H_IDLE) ? 16'h0000 : div + 16'h0001;
      scl_r <= scl_c;
      oe_r  <= oe_c;
    end
  end

  assign bus.scl         = scl_r;
  assign bus.host_sda_oe = oe_r;

  // ---------------------------------------------------------------
  // transfer sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= H_IDLE;
      q       <= 2'd0;
      bitc    <= 4'd0;
      bytec   <= 8'h00;
      rxsh    <= 8'h00;
      ack_bad <= 1'b0;
    end else if (state == H_IDLE) begin
      q    <= 2'd0;
      bitc <= 4'd0;
      if (go) begin
        state <= H_START;
      end
    end else if (adv) begin
      q <= q + 2'd1;
      if (q == 2'd2 && is_byte) begin
        if (state == H_RDATA && bitc < 4'd8) begin
          rxsh <= {rxsh[6:0], bus.sda};
        end else if (bitc == 4'd8) begin
          ack_bad <= bus.sda;
        end
      end
      if (q == 2'd3) begin
        if (is_byte && bitc < 4'd8) begin
          bitc <= bitc + 4'd1;
        end else begin
          bitc <= 4'd0;
          unique case (state)
            H_START:  state <= H_SAW;
            H_SAW:    state <= ack_bad ? H_STOP : H_REG;
            H_REG: begin
              state <= ack_bad ? H_STOP : (cmd_rd ? H_RSTART : H_WDATA);
              bytec <= 8'h00;
            end
            H_WDATA: begin
              bytec <= bytec + 8'h01;
              if (ack_bad || bytec == 8'h03) begin
                state <= H_STOP;
              end
            end
            H_RSTART: state <= H_SAR;
            H_SAR: begin
              state <= ack_bad ? H_STOP : H_RDATA;
              bytec <= 8'h00;
            end
            H_RDATA: begin
              bytec <= bytec + 8'h01;
              if (last || abort) begin
                state <= H_STOP;
              end
            end
            default:  state <= H_IDLE;
          endcase
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nack_err <= 1'b0;
    end else if (adv && q == 2'd3 && is_byte && state != H_RDATA && bitc == 4'd8 && ack_bad) begin
      nack_err <= 1'b1;
    end else if (go) begin
      nack_err <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // receive fifo
  // ---------------------------------------------------------------
  ifrl_fifo #(.W(8), .D(DEPTH)) rx_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (push),
    .in_data   (rxsh),
    .in_ready  (f_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (psel & penable & ~pwrite & paddr == APB_RXDATA & prdata[8])
  );

  // ---------------------------------------------------------------
  // field joiner over each eight-byte group from 0x28
  // ---------------------------------------------------------------
  assign jw = {jbuf, rxsh};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jbuf    <= '0;
      jidx    <= 3'd0;
      join_v  <= 1'b0;
      join_xy <= 32'h00000000;
      join_zt <= 32'h00000000;
    end else if (state == H_RSTART || go) begin
      jidx   <= 3'd0;
      join_v <= go ? 1'b0 : join_v;
    end else if (push && cmd_reg == REG_HI) begin
      jbuf <= jw[55:0];
      jidx <= jidx + 3'd1;
      if (jidx == 3'd7) begin
        join_xy <= {sx({jw[63:56], jw[19:16]}), sx({jw[55:48], jw[15:12]})}; // R10
        join_zt <= {sx({jw[47:40], jw[11:8]}), 4'h0, jw[37:32], jw[5:0]}; // R10
        join_v  <= 1'b1; // R12
      end
    end
  end

endmodule : ifrl_host

`default_nettype wire

//--- bench/ifrl_assertions.sv
/* checks on the two-wire link between host and sensor ends.
   assumes a host built with a quarter of 2 pclk cycles. */
`timescale 1ns/10ps
`default_nettype none
module ifrl_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ---------------------------------------------------------------
  // link timing
  // ---------------------------------------------------------------
  property p_rst_idle;
    $rose(presetn) |-> (scl && !host_sda_oe && !dev_sda_oe) [*4];
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("link not idle after reset");
  property p_scl_high;
    $rose(scl) |-> scl [*4];
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("scl high time wrong");
  property p_scl_low;
    $fell(scl) |-> !scl [*4];
  endproperty
  a_scl_low: assert property (p_scl_low) else $error("scl low time short");
  property p_dev_change;
    $changed(dev_sda_oe) |-> !$past(scl) && $past(scl, 2);
  endproperty
  a_dev_change: assert property (p_dev_change) else $error("sensor moved sda late");
  property p_dev_quiet_high;
    scl && $past(scl) |-> $stable(dev_sda_oe);
  endproperty
  a_dev_quiet_high: assert property (p_dev_quiet_high) else $error("sda moved, scl high");
  property p_sda_resolved;
    sda == !(host_sda_oe || dev_sda_oe);
  endproperty
  a_sda_resolved: assert property (p_sda_resolved) else $error("sda level wrong");
  property p_start;
    $rose(host_sda_oe) && scl |-> ##[1:3] !scl;
  endproperty
  a_start: assert property (p_start) else $error("start not followed by scl low");
  property p_stop;
    $fell(host_sda_oe) && scl |-> $past(scl, 2);
  endproperty
  a_stop: assert property (p_stop) else $error("stop without scl high");
endmodule : ifrl_assertions
`default_nettype wire

//--- bench/test_i2c_field_readback_loop.sv
/* bench of the field readback loop: host and sensor ends joined by ifrl_if.
   assumes the design files and the checker compiled before it. */
`timescale 1ns/10ps
`default_nettype none
module test_i2c_field_readback_loop;
  import ifrl_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, perr, pready, pslverr, sleep, unlocked;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, hi, lo;
  logic [1:0]  loop_mode;
  logic [11:0] xf, yf, zf, tf;
  logic [7:0]  q[$];
  int          num_errors, cmp_count;
  ifrl_if u_ifrl_if ();
  ifrl_host #(.QUARTER(2)) u_ifrl_host (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(u_ifrl_if));
  ifrl_dev u_ifrl_dev (.pclk(pclk), .presetn(presetn), .bus(u_ifrl_if), .x_field(xf),
    .y_field(yf), .z_field(zf), .temp_field(tf), .loop_mode(loop_mode), .sleep(sleep),
    .unlocked(unlocked));
  ifrl_assertions u_ifrl_assertions (.pclk(pclk), .presetn(presetn), .scl(u_ifrl_if.scl),
    .host_sda_oe(u_ifrl_if.host_sda_oe), .dev_sda_oe(u_ifrl_if.dev_sda_oe),
    .sda(u_ifrl_if.sda));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic idle();
    for (int i = 0; i < 4000; i++) begin
      apb(1'b0, APB_STATUS, 32'h0);
      if (rd[0] === 1'b0) break;
    end
  endtask : idle
  task automatic cmd(input logic [7:0] r, input logic [31:0] d);
    apb(1'b1, APB_WDATA, d);
    apb(1'b1, APB_CTRL, {16'h0, r, 8'h01});
    idle();
  endtask : cmd
  task automatic word(input logic [31:0] w);
    for (int i = 3; i >= 0; i--) q.push_back(w[i*8+:8]);
  endtask : word
  task automatic pop(input logic [7:0] n);
    if (n != 8'h0) apb(1'b1, APB_CTRL, {8'h0, n, REG_HI, 8'h03});
    while (q.size() > 0) begin
      apb(1'b0, APB_RXDATA, 32'h0);
      if (rd[8] === 1'b1) chk("rx byte", {24'h1, q.pop_front()}, rd);
    end
    idle();
  endtask : pop
  task automatic newf();
    @(posedge pclk);
    xf <= 12'($urandom);
    yf <= 12'($urandom);
    zf <= 12'($urandom);
    tf <= 12'($urandom);
    @(posedge pclk);
    hi = {xf[11:4], yf[11:4], zf[11:4], 2'b0, tf[11:6]};
    lo = {12'h0, xf[3:0], yf[3:0], zf[3:0], 2'b0, tf[5:0]};
  endtask : newf
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (50000) @(posedge pclk);
    num_errors++;
    results();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    {xf, yf, zf, tf} = 48'h0;
    void'($urandom(32'h3104));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, APB_STATUS, 32'h0);
    chk("status", 32'h0, rd);
    chk("loop mode", 32'h0, {30'h0, loop_mode});
    cmd(REG_CFG, 32'h9);
    chk("sleep", 32'h1, {31'h0, sleep});
    chk("loop mode", 32'h0, {30'h0, loop_mode});
    cmd(REG_KEY, KEY_VALUE);
    chk("unlocked", 32'h1, {31'h0, unlocked});
    cmd(REG_HI, 32'hffffffff);
    newf();
    word(hi);
    word(lo);
    pop(8'd8);
    apb(1'b0, APB_JOIN_XY, 32'h0);
    chk("join xy", {{4{xf[11]}}, xf, {4{yf[11]}}, yf}, rd);
    apb(1'b0, APB_JOIN_ZT, 32'h0);
    chk("join zt", {{4{zf[11]}}, zf, 4'h0, tf}, rd);
    apb(1'b0, APB_STATUS, 32'h0);
    chk("join valid", 32'h8, rd);
    for (int m = 1; m < 4; m++) begin
      cmd(REG_CFG, 32'(m << 2));
      chk("loop mode", 32'(m), {30'h0, loop_mode});
      newf();
      word(hi);
      word(m == 1 ? hi : lo);
      word(m == 3 ? 32'h0 : hi);
      pop(8'd12);
    end
    cmd(REG_CFG, 32'h4);
    apb(1'b1, APB_CTRL, {8'h0, 8'd20, REG_HI, 8'h03});
    repeat (2000) @(posedge pclk);
    apb(1'b0, APB_STATUS, 32'h0);
    chk("full fifo status", 32'h5, rd & 32'h7);
    for (int i = 0; i < 5; i++) word(hi);
    pop(8'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, perr});
    chk("unmapped data", 32'h0, rd);
    results();
  end
endmodule : test_i2c_field_readback_loop
`default_nettype wire
